// file: logic/pci_cfg_pkg.sv
// shared offsets, command field layout and encodings for the configuration block
package pci_cfg_pkg;

  localparam int FUNC_COUNT = 2;

  // configuration offsets (byte addresses)
  localparam logic [7:0] OFS_MANUFACTURER_CODE = 8'h00;
  localparam logic [7:0] OFS_PART_CODE         = 8'h02;
  localparam logic [7:0] OFS_BUS_IF_CONTROL    = 8'h04;

  // bus_interface_control field positions
  localparam int CMD_IO_SPACE_BIT       = 0;
  localparam int CMD_MEM_SPACE_BIT      = 1;
  localparam int CMD_INITIATOR_BIT      = 2;
  localparam int CMD_SPECIAL_CYCLE_BIT  = 3;
  localparam int CMD_WRITE_INVAL_BIT    = 4;
  localparam int CMD_PALETTE_SNOOP_BIT  = 5;
  localparam int CMD_PARITY_RESP_BIT    = 6;
  localparam int CMD_STEPPING_BIT       = 7;
  localparam int CMD_SYS_ERR_REPORT_BIT = 8;
  localparam int CMD_BACK_TO_BACK_BIT   = 9;

  localparam logic [15:0] CMD_RESET_VALUE   = 16'h0000;
  localparam logic [15:0] CMD_WRITABLE_MASK = 16'h0167;
  localparam logic [15:0] STATUS_READ_VALUE = 16'h0000;

  // bus command encodings on the initiator side
  localparam logic [3:0] BUS_CMD_MEM_WRITE        = 4'h7;
  localparam logic [3:0] BUS_CMD_WRITE_INVALIDATE = 4'hF;

  // target space encodings
  localparam logic [1:0] SPACE_NONE = 2'h0;
  localparam logic [1:0] SPACE_MEM  = 2'h1;
  localparam logic [1:0] SPACE_IO   = 2'h2;

  // error pins are asserted for one clock per event
  localparam int ERR_PULSE_CYCLES = 1;

  typedef enum logic [1:0] {
    MST_IDLE    = 2'b00,
    MST_REQUEST = 2'b01,
    MST_OWNER   = 2'b11,
    MST_RELEASE = 2'b10
  } master_state_t;

endpackage

// file: logic/func_command_reg.sv
// one function's bus interface control register with byte lane writes
`timescale 1ns/1ns
module func_command_reg (
  input  wire logic        clk,
  input  wire logic        nrst,
  input  wire logic        wrEn,
  input  wire logic [1:0]  byteEn,
  input  wire logic [15:0] wdata,
  output logic      [15:0] cmd
);
  import pci_cfg_pkg::*;

  logic [15:0] laneMask;

  always_comb begin
    laneMask = {{8{byteEn[1]}}, {8{byteEn[0]}}};
  end

  // hardwired and reserved bits never take a write
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      cmd <= CMD_RESET_VALUE;
    end else if (wrEn) begin
      cmd <= (cmd & ~(laneMask & CMD_WRITABLE_MASK)) | (wdata & laneMask & CMD_WRITABLE_MASK);
    end
  end

endmodule

// file: logic/error_pin_driver.sv
// open-drain error pin: one-clock low pulse, driver gated by an enable
`timescale 1ns/1ns
module error_pin_driver (
  input  wire logic clk,
  input  wire logic nrst,
  input  wire logic fire,
  input  wire logic driverEnable,
  output logic      pinOut,
  output logic      pinOe
);
  import pci_cfg_pkg::*;

  logic [1:0] pulseCount;

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      pulseCount <= 2'h0;
    end else if (fire && driverEnable) begin
      pulseCount <= 2'(ERR_PULSE_CYCLES);
    end else if (pulseCount != 2'h0) begin
      pulseCount <= pulseCount - 2'h1;
    end
  end

  // pin released to the pull-up whenever the driver is disabled
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      pinOut <= 1'b1;
      pinOe  <= 1'b1;
    end else begin
      pinOut <= 1'b0;
      pinOe  <= !((fire || (pulseCount > 2'h1)) && driverEnable);
    end
  end

endmodule

// file: logic/pci_config_command_id.sv
// identification and bus interface control registers of a two-function bridge
`timescale 1ns/1ns

module pci_config_command_id #(
  parameter logic [15:0] MANUFACTURER_CODE = 16'h1234, // arbitrary value
  parameter logic [15:0] PART_CODE         = 16'h5678  // arbitrary value
) (
  input  wire logic        clk,
  input  wire logic        nrst,
  input  wire logic        cfgAccess,
  input  wire logic        cfgWrite,
  input  wire logic        cfgFunc,
  input  wire logic [7:0]  cfgAddr,
  input  wire logic [3:0]  cfgByteEn,
  input  wire logic [31:0] cfgWdata,
  output logic      [31:0] cfgRdata,
  output logic             cfgDone,
  input  wire logic        targetValid,
  input  wire logic        targetFunc,
  input  wire logic [1:0]  targetSpace,
  input  wire logic        targetWrite,
  input  wire logic        targetPalette,
  input  wire logic        targetSpecial,
  input  wire logic [7:0]  targetData,
  output logic             targetClaim,
  output logic             targetClaimFunc,
  output logic             paletteCapture,
  output logic      [7:0]  paletteData,
  input  wire logic [1:0]  masterReq,
  input  wire logic [7:0]  masterCmd,
  input  wire logic        busGrant,
  input  wire logic        masterDone,
  output logic             busRequest,
  output logic             masterActive,
  output logic             masterFunc,
  output logic      [3:0]  busCmd,
  output logic             backToBackActive,
  input  wire logic        addrParityErr,
  input  wire logic        dataParityErr,
  output logic             serrOut,
  output logic             serrOe,
  output logic             perrOut,
  output logic             perrOe,
  output logic             parityResponseActive,
  output logic             systemErrorReportActive
);
  import pci_cfg_pkg::*;

  logic [15:0]       cmdReg [FUNC_COUNT];
  logic [15:0]       cmdView [FUNC_COUNT];
  logic [FUNC_COUNT-1:0] ioEnable;
  logic [FUNC_COUNT-1:0] memEnable;
  logic [FUNC_COUNT-1:0] initiator_enable;
  logic [FUNC_COUNT-1:0] paletteSnoop;
  logic [FUNC_COUNT-1:0] parity_response_enable;
  logic [FUNC_COUNT-1:0] system_error_report_enable;
  logic [FUNC_COUNT-1:0] cmdWrite;
  logic              parityEnAny;
  logic              sysErrEnAny;
  logic              addrIsId;
  logic              addrIsCmd;
  logic [31:0]       next_cfgRdata;
  logic              snoopHit;
  logic              next_targetClaim;
  logic [3:0]        ownerCmd;
  logic              ownerFunc;
  logic              pickValid;
  logic              pickFunc;
  logic              lastOwner;
  master_state_t     mstState;
  master_state_t     next_mstState;

  // one control register per function
  genvar f;
  generate
    for (f = 0; f < FUNC_COUNT; f = f + 1) begin : g_func
      assign cmdWrite[f] = cfgAccess && cfgWrite && (cfgFunc == 1'(f)) && addrIsCmd;

      func_command_reg u_cmd (
        .clk    (clk),
        .nrst   (nrst),
        .wrEn   (cmdWrite[f]),
        .byteEn (cfgByteEn[1:0]),
        .wdata  (cfgWdata[15:0]),
        .cmd    (cmdReg[f])
      );

      // read-only bits forced low on the way out as well
      always_comb begin
        cmdView[f] = cmdReg[f] & CMD_WRITABLE_MASK;
      end

      assign ioEnable[f]                   = cmdReg[f][CMD_IO_SPACE_BIT];
      assign memEnable[f]                  = cmdReg[f][CMD_MEM_SPACE_BIT];
      assign initiator_enable[f]           = cmdReg[f][CMD_INITIATOR_BIT];
      assign paletteSnoop[f]               = cmdReg[f][CMD_PALETTE_SNOOP_BIT];
      assign parity_response_enable[f]     = cmdReg[f][CMD_PARITY_RESP_BIT];
      assign system_error_report_enable[f] = cmdReg[f][CMD_SYS_ERR_REPORT_BIT];
    end
  endgenerate

  // error enables look separate to software but act as one
  assign parityEnAny = |parity_response_enable;
  assign sysErrEnAny = |system_error_report_enable;

  // configuration decode works on whole dwords
  assign addrIsId  = (cfgAddr[7:2] == OFS_MANUFACTURER_CODE[7:2]);
  assign addrIsCmd = (cfgAddr[7:2] == OFS_BUS_IF_CONTROL[7:2]);

  always_comb begin
    next_cfgRdata = 32'h0000_0000;
    if (addrIsId) begin
      next_cfgRdata[OFS_PART_CODE[1:0]*8 +: 16]         = PART_CODE;
      next_cfgRdata[OFS_MANUFACTURER_CODE[1:0]*8 +: 16] = MANUFACTURER_CODE;
    end else if (addrIsCmd) begin
      next_cfgRdata = {STATUS_READ_VALUE, cmdView[cfgFunc]};
    end
  end

  // read data and completion strobe follow the access by one clock
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      cfgDone <= 1'b0;
    end else begin
      cfgDone <= cfgAccess;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      cfgRdata <= 32'h0000_0000;
    end else if (cfgAccess && !cfgWrite) begin
      cfgRdata <= next_cfgRdata;
    end
  end

  // target claim decision
  assign snoopHit = targetValid && targetPalette && targetWrite && paletteSnoop[targetFunc];

  always_comb begin
    next_targetClaim = 1'b0;
    if (targetValid && !targetSpecial && !snoopHit) begin
      case (targetSpace)
        SPACE_MEM: begin
          next_targetClaim = memEnable[targetFunc];
        end
        SPACE_IO: begin
          next_targetClaim = ioEnable[targetFunc];
        end
        default: begin
          next_targetClaim = 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      targetClaim <= 1'b0;
    end else begin
      targetClaim <= next_targetClaim;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      targetClaimFunc <= 1'b0;
    end else if (targetValid) begin
      targetClaimFunc <= targetFunc;
    end
  end

  // snooped palette data is kept until the next snooped write
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      paletteCapture <= 1'b0;
    end else begin
      paletteCapture <= snoopHit;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      paletteData <= 8'h00;
    end else if (snoopHit) begin
      paletteData <= targetData;
    end
  end

  // initiator arbitration between the two functions, alternating on ties
  always_comb begin
    pickValid = 1'b0;
    pickFunc  = 1'b0;
    if (masterReq[0] && initiator_enable[0] && masterReq[1] && initiator_enable[1]) begin
      pickValid = 1'b1;
      pickFunc  = !lastOwner;
    end else if (masterReq[0] && initiator_enable[0]) begin
      pickValid = 1'b1;
      pickFunc  = 1'b0;
    end else if (masterReq[1] && initiator_enable[1]) begin
      pickValid = 1'b1;
      pickFunc  = 1'b1;
    end
  end

  // write-invalidate never leaves the device; a plain write goes instead
  always_comb begin
    ownerCmd = masterCmd[masterFunc*4 +: 4];
    if (ownerCmd == BUS_CMD_WRITE_INVALIDATE) begin
      ownerCmd = BUS_CMD_MEM_WRITE;
    end
  end

  assign ownerFunc = masterFunc;

  always_comb begin
    next_mstState = mstState;
    case (mstState)
      MST_IDLE: begin
        if (pickValid) begin
          next_mstState = MST_REQUEST;
        end
      end
      MST_REQUEST: begin
        // a request withdrawn or disabled before the grant is dropped
        if (!masterReq[ownerFunc] || !initiator_enable[ownerFunc]) begin
          next_mstState = MST_IDLE;
        end else if (busGrant) begin
          next_mstState = MST_OWNER;
        end
      end
      MST_OWNER: begin
        // a tenure already granted runs to completion
        if (masterDone) begin
          next_mstState = MST_RELEASE;
        end
      end
      MST_RELEASE: begin
        next_mstState = MST_IDLE;
      end
      default: begin
        next_mstState = MST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      mstState <= MST_IDLE;
    end else begin
      mstState <= next_mstState;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      masterFunc <= 1'b0;
    end else if (mstState == MST_IDLE && pickValid) begin
      masterFunc <= pickFunc;
    end
  end

  // remembered at release so the next tie goes to the other function
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      lastOwner <= 1'b1;
    end else if (mstState == MST_RELEASE) begin
      lastOwner <= masterFunc;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      busRequest   <= 1'b0;
      masterActive <= 1'b0;
    end else begin
      busRequest   <= (next_mstState == MST_REQUEST);
      masterActive <= (next_mstState == MST_OWNER);
    end
  end

  // command frozen at grant so a later change cannot disturb the tenure
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      busCmd <= 4'h0;
    end else if (mstState == MST_REQUEST && next_mstState == MST_OWNER) begin
      busCmd <= ownerCmd;
    end
  end

  // fast back-to-back is never generated, the flag stays low
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      backToBackActive <= 1'b0;
    end else begin
      backToBackActive <= 1'b0;
    end
  end

  // error reporting
  error_pin_driver u_serr (
    .clk          (clk),
    .nrst         (nrst),
    .fire         (addrParityErr && parityEnAny),
    .driverEnable (sysErrEnAny),
    .pinOut       (serrOut),
    .pinOe        (serrOe)
  );

  error_pin_driver u_perr (
    .clk          (clk),
    .nrst         (nrst),
    .fire         (dataParityErr),
    .driverEnable (parityEnAny),
    .pinOut       (perrOut),
    .pinOe        (perrOe)
  );

  // effective combined enables, visible to the rest of the bridge
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      parityResponseActive <= 1'b0;
    end else begin
      parityResponseActive <= parityEnAny;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      systemErrorReportActive <= 1'b0;
    end else begin
      systemErrorReportActive <= sysErrEnAny;
    end
  end

endmodule

// file: verification/cfg_cmd_chk.sv
// port assertions for the id and bus interface control block
`timescale 1ns/1ns
module cfg_cmd_chk (
  input wire logic        clk,
  input wire logic        nrst,
  input wire logic        cfgAccess,
  input wire logic        cfgWrite,
  input wire logic [7:0]  cfgAddr,
  input wire logic [31:0] cfgRdata,
  input wire logic        targetValid,
  input wire logic        targetFunc,
  input wire logic [1:0]  targetSpace,
  input wire logic        targetWrite,
  input wire logic        targetPalette,
  input wire logic        targetSpecial,
  input wire logic [7:0]  targetData,
  input wire logic        targetClaim,
  input wire logic        targetClaimFunc,
  input wire logic        paletteCapture,
  input wire logic [7:0]  paletteData,
  input wire logic        busRequest,
  input wire logic        masterActive,
  input wire logic [3:0]  busCmd,
  input wire logic        addrParityErr,
  input wire logic        dataParityErr,
  input wire logic        serrOe,
  input wire logic        perrOe,
  input wire logic        parityResponseActive,
  input wire logic        systemErrorReportActive
);
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);
  a_fixed_zero: assert property (cfgAccess && !cfgWrite && cfgAddr[7:2] == 6'h01
    |=> (cfgRdata & 32'hFFFFFE98) == 32'h0) else $error("fixed bits set");
  a_no_wrinval: assert property (masterActive |-> busCmd != 4'hF)
    else $error("bad command");
  a_owner_req: assert property ($rose(masterActive) |-> $past(busRequest))
    else $error("owner without request");
  a_special_ign: assert property (targetValid && targetSpecial |=> !targetClaim)
    else $error("special claimed");
  a_claim_space: assert property (targetClaim |-> $past(targetValid) && $past(targetSpace) inside {2'h1, 2'h2}
    && targetClaimFunc == $past(targetFunc)) else $error("bad claim");
  a_snoop_grab: assert property (paletteCapture |-> !targetClaim && paletteData == $past(targetData)
    && $past(targetValid && targetPalette && targetWrite)) else $error("bad capture");
  // the active flags are registered like the pins, so both line up with the past error
  a_serr_gate: assert property (serrOe == !($past(addrParityErr)
    && systemErrorReportActive && parityResponseActive)) else $error("serr pin wrong");
  a_perr_gate: assert property (perrOe == !($past(dataParityErr) && parityResponseActive))
    else $error("perr pin wrong");
  c_claim: cover property (targetClaim);
  c_owner: cover property ($rose(masterActive));
  c_serr: cover property (!serrOe);
endmodule

// file: verification/host_bridge_model.sv
// host bridge: configuration cycles and a one-master arbiter
`timescale 1ns/1ns
module host_bridge_model (
  input  wire logic        clk,
  input  wire logic        cfgDone,
  input  wire logic [31:0] cfgRdata,
  input  wire logic        busRequest,
  input  wire logic        masterActive,
  output logic             cfgAccess,
  output logic             cfgWrite,
  output logic             cfgFunc,
  output logic      [7:0]  cfgAddr,
  output logic      [3:0]  cfgByteEn,
  output logic      [31:0] cfgWdata,
  output logic             busGrant,
  output logic             masterDone
);
  int grantWait = 0; // raised by the bench for a slow arbiter
  int waitCnt   = 0;
  initial begin
    {cfgAccess, cfgWrite, cfgFunc, cfgByteEn} = '0;
    {cfgAddr, cfgWdata} = '1;
  end
  task automatic access(input logic w, input logic f, input logic [7:0] a, input logic [3:0] be,
                        input logic [15:0] d, output logic [31:0] r);
    @(negedge clk);
    {cfgAccess, cfgWrite, cfgFunc, cfgAddr, cfgByteEn} = {1'b1, w, f, a, be};
    cfgWdata = {16'h0, d};
    @(negedge clk);
    r = cfgDone ? cfgRdata : 32'hXXXXXXXX;
    cfgAccess = 1'b0;
    cfgWdata = ~cfgWdata; // released lines must not keep the old value
    cfgAddr = ~cfgAddr;
  endtask
  always @(negedge clk) begin
    waitCnt <= busRequest ? waitCnt + 1 : 0;
    busGrant <= busRequest && waitCnt >= grantWait;
    masterDone <= masterActive && !masterDone; // one data phase per tenure
  end
endmodule

// file: verification/testbench.sv
// self-checking bench for the id and bus interface control block
`timescale 1ns/1ns
`define CHK(nm, exp, got) begin nTests++; if ((got) !== (exp)) begin nFail++; \
  $display("[FAIL] %s expected %0h seen %0h", nm, exp, got); end end
module testbench;
  import pci_cfg_pkg::*;
  localparam logic [15:0] MAN = 16'h1234; // arbitrary value
  localparam logic [15:0] PRT = 16'h5678; // arbitrary value
  logic        clk = 1'b0;
  logic        nrst = 1'b0;
  logic        targetValid, targetFunc, targetWrite, targetPalette, targetSpecial, cfgAccess, cfgWrite, cfgFunc;
  logic [1:0]  targetSpace, masterReq;
  logic [7:0]  targetData, masterCmd, cfgAddr, paletteData;
  logic [3:0]  cfgByteEn, busCmd;
  logic [31:0] cfgWdata, cfgRdata, rd;
  logic        addrParityErr, dataParityErr, cfgDone, targetClaim, targetClaimFunc, paletteCapture;
  logic        busGrant, masterDone, busRequest, masterActive, masterFunc, backToBackActive;
  logic        serrOut, serrOe, perrOut, perrOe, parityResponseActive, systemErrorReportActive;
  logic [31:0] seed = 32'h00009EEF;
  logic [15:0] cmdM [2];
  logic        seen, expC, expP;
  int          nFail = 0;
  int          nTests = 0;
  int          k;
  pci_config_command_id #(.MANUFACTURER_CODE(MAN), .PART_CODE(PRT)) i_pci_config_command_id (.*);
  host_bridge_model i_host_bridge_model (.*);
  initial begin
    forever #10 clk = ~clk;
  end
  initial begin
    #200000;
    nFail++; // hang
    endSim();
  end
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  task automatic endSim();
    $display("comparisons %0d mismatches %0d", nTests, nFail);
    if (nFail == 0 && nTests > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  task automatic wr(input int f, input logic [3:0] be, input logic [15:0] d);
    i_host_bridge_model.access(1'b1, f[0], 8'h04, be, d, rd);
    if (be[0]) cmdM[f][7:0] = d[7:0] & 8'h67;
    if (be[1]) cmdM[f][15:8] = d[15:8] & 8'h01;
  endtask
  task automatic rdchk(input int f, input logic [7:0] a, input logic [31:0] exp);
    i_host_bridge_model.access(1'b0, f[0], a, 4'hF, 16'h0, rd);
    `CHK("read", exp, rd)
  endtask
  task automatic tgt(input logic [5:0] i);
    @(negedge clk);
    {targetSpecial, targetPalette, targetWrite, targetSpace, targetFunc} = i;
    targetPalette = i[4] & ~i[5];
    void'(rnd());
    targetData = seed[7:0];
    targetValid = 1'b1;
    expP = targetPalette && targetWrite && cmdM[targetFunc][5];
    expC = !targetSpecial && !expP && (targetSpace == 2'h1 && cmdM[targetFunc][1]
           || targetSpace == 2'h2 && cmdM[targetFunc][0]);
    @(negedge clk);
    targetValid = 1'b0;
    `CHK("claim", expC, targetClaim)
    `CHK("claim func", targetFunc, targetClaimFunc)
    `CHK("capture", expP, paletteCapture)
    if (expP) `CHK("palette", targetData, paletteData)
    targetData = ~targetData;
  endtask
  task automatic perr(input logic [15:0] e0, input logic [15:0] e1);
    wr(0, 4'h3, e0);
    wr(1, 4'h3, e1);
    repeat (3) @(negedge clk);
    `CHK("par act", cmdM[0][6] | cmdM[1][6], parityResponseActive)
    `CHK("sys act", cmdM[0][8] | cmdM[1][8], systemErrorReportActive)
    {addrParityErr, dataParityErr} = 2'b11;
    @(negedge clk);
    {addrParityErr, dataParityErr} = 2'b00;
    `CHK("serr", ~((cmdM[0][8] | cmdM[1][8]) & (cmdM[0][6] | cmdM[1][6])), serrOe)
    `CHK("perr", ~(cmdM[0][6] | cmdM[1][6]), perrOe)
    `CHK("pin level", 2'b00, {serrOut, perrOut})
    @(negedge clk);
    `CHK("pins idle", 2'b11, {serrOe, perrOe})
  endtask
  initial begin
    {targetValid, targetFunc, targetWrite, targetPalette, targetSpecial, targetSpace} = '0;
    {masterReq, targetData, masterCmd, addrParityErr, dataParityErr} = '0;
    cmdM = '{16'h0, 16'h0};
    repeat (6) @(posedge clk);
    @(negedge clk);
    nrst = 1'b1;
    for (int f = 0; f < 2; f++) begin
      rdchk(f, 8'h00, {PRT, MAN});
      rdchk(f, 8'h04, 32'h0);
      i_host_bridge_model.access(1'b1, f[0], 8'h00, 4'hF, 16'hFFFF, rd);
      rdchk(f, 8'h00, {PRT, MAN});
      rdchk(f, 8'h0C, 32'h0);
    end
    $display("ids done");
    repeat (24) begin
      void'(rnd());
      wr(int'(seed[8]), seed[1:0], seed[31:16]);
      rdchk(0, 8'h04, {16'h0, cmdM[0]});
      rdchk(1, 8'h04, {16'h0, cmdM[1]});
    end
    $display("control done");
    repeat (4) begin
      void'(rnd());
      wr(0, 4'h3, seed[15:0]);
      wr(1, 4'h3, seed[31:16]);
      for (int i = 0; i < 64; i++) begin
        tgt(i[5:0]);
      end
    end
    $display("target done");
    masterCmd = 8'h6F;
    for (int f = 0; f < 2; f++) begin
      i_host_bridge_model.grantWait = 3 * f;
      wr(f, 4'h3, 16'h0000);
      masterReq = 2'h1 << f;
      seen = 1'b0;
      repeat (10) begin
        @(negedge clk);
        seen |= busRequest;
      end
      `CHK("req off", 1'b0, seen)
      wr(f, 4'h3, 16'h0004);
      k = 0;
      while (!masterActive && k < 20) begin
        @(negedge clk);
        k++;
      end
      `CHK("owner", 1'b1, masterActive)
      `CHK("owner func", f[0], masterFunc)
      `CHK("command", f ? 4'h6 : 4'h7, busCmd)
      `CHK("no b2b", 1'b0, backToBackActive)
      @(negedge clk);
      masterReq = 2'h0;
      wr(f, 4'h3, 16'h0000);
    end
    $display("master done");
    perr(16'h0000, 16'h0000);
    perr(16'h0100, 16'h0000);
    perr(16'h0100, 16'h0040);
    perr(16'h0000, 16'h0040);
    $display("errors done");
    endSim();
  end
endmodule
bind pci_config_command_id cfg_cmd_chk i_cfg_cmd_chk (.*);
